/* File: common/wdtw_map.svh */
// Field positions, bit positions, divide ratios and timing counts of the watchdog
`ifndef WDTW_MAP_SVH
`define WDTW_MAP_SVH
// System clock period in ns
`define WDTW_SYS_PERIOD_NS    50
// Nominal RC oscillator period in ns (32 kHz)
`define WDTW_RC_PERIOD_NS     31250
// Half period of the RC oscillator in system clocks, rounded down
`define WDTW_RC_HALF_CYC      (`WDTW_RC_PERIOD_NS / 2 / `WDTW_SYS_PERIOD_NS)
// Prescaler divide ratios
`define WDTW_PRE_DIV_SHORT    32
`define WDTW_PRE_DIV_LONG     128
// Configuration word field positions
`define WDTW_CFG_POST_LSB     0
`define WDTW_CFG_POST_MSB     3
`define WDTW_CFG_PRE_BIT      4
`define WDTW_CFG_WINDOW_DISABLE_BIT_BIT   6
`define WDTW_CFG_FUSE_EN_BIT  7
// Reset-control register bit positions
`define WDTW_RESET_CONTROL_REG_IDLE_BIT    2
`define WDTW_RESET_CONTROL_REG_SLEEP_BIT   3
`define WDTW_RESET_CONTROL_REG_TO_BIT      4
`define WDTW_RESET_CONTROL_REG_SWEN_BIT    5
// Postscaler counter width (2^15 maximum ratio)
`define WDTW_POST_W           16
`define WDTW_POST_MAX_SEL     15
`endif

/* File: common/wdtw_pkg.sv */
// Types shared by the watchdog modules
`include "wdtw_map.svh"
package wdtw_pkg;
  typedef enum logic [1:0] {
    WDTW_RUN,
    WDTW_LOWPWR,
    WDTW_WAKE
  } wdtw_state_t;
  typedef logic [`WDTW_POST_W-1:0] wdtw_post_t;
endpackage

/* File: common/wdtw_tick_if.sv */
// Carrier between the RC oscillator model and the watchdog core
`timescale 1ns/100ps
interface wdtw_tick_if;
  logic run;
  logic tick;
  modport src (input run, output tick);
  modport dst (output run, input tick);
endinterface

/* File: logic/wdtw_rc_osc.sv */
// Low-power RC oscillator stand-in: a tick at the nominal 32 kHz rate
`timescale 1ns/100ps
`include "wdtw_map.svh"
module wdtw_rc_osc
  import wdtw_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst,
  wdtw_tick_if.src  osc
);
  localparam int CW = 10;
  localparam logic [CW-1:0] HALF = CW'(`WDTW_RC_HALF_CYC - 1);
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          ph_r;
  logic          ph_nxt;
  logic          tick_r;
  logic          tick_nxt;

  // --------------------------------------------------------
  // Oscillator divider
  // --------------------------------------------------------
  // Stopped and reset whenever the watchdog is off, saving power
  always_comb begin
    cnt_nxt  = cnt_r;
    ph_nxt   = ph_r;
    tick_nxt = 1'b0;
    if (!osc.run) begin
      cnt_nxt = '0;
      ph_nxt  = 1'b0;
    end else if (cnt_r == HALF) begin
      cnt_nxt  = '0;
      ph_nxt   = ~ph_r;
      tick_nxt = ph_r; // One tick per full RC period
    end else begin
      cnt_nxt = cnt_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_r  <= '0;
      ph_r   <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      ph_r   <= ph_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign osc.tick = tick_r;
endmodule

/* File: logic/wdtw_core.sv */
// Windowed watchdog timer with prescaler, postscaler and wake-up
// How it works
// - RC oscillator runs whenever the watchdog is enabled, whatever the system clock.
// - Prescaler divides the RC clock by 32 or 128 per prescale select.
// - Prescaler period is about 1 ms or 4 ms at nominal clock.
// - Four-bit postscale select gives sixteen ratios from 1:1 to 1:32768.
// - Completed clock switch clears counter, prescaler and postscaler.
// - Power-save instruction entering sleep or idle clears all counters.
// - Leaving sleep or idle clears all counters.
// - Clear instruction in normal operation clears all counters.
// - Watchdog keeps counting in sleep and idle when enabled.
// - Time-out in sleep or idle wakes the device without reset.
// - Time-out flag is sticky; only software or device reset clears it.
// - Fuse enable set keeps the watchdog always running.
// - Fuse enable clear: watchdog runs only while soft enable is set.
// - Device reset clears the soft enable bit.
// - Early clear in window mode causes a watchdog reset at postscale ratios of 1:4 and above.
`timescale 1ns/100ps
`include "wdtw_map.svh"
module wdtw_core
  import wdtw_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [7:0] watchdog_config_word,
  input  wire logic       soft_enable_set,
  input  wire logic       soft_enable_clr,
  input  wire logic       timeout_flag_clr,
  input  wire logic       watchdog_clear_instr,
  input  wire logic       power_save_instr,
  input  wire logic       osc_switch_done,
  input  wire logic       low_power_exit,
  output logic            low_power_rc_osc_en,
  output logic            soft_enable_bit,
  output logic            timeout_flag,
  output logic            watchdog_reset,
  output logic            wake_request,
  output logic            in_low_power
);
  wdtw_tick_if osc_if ();

  wdtw_state_t   st_r, st_nxt;
  logic [6:0]    pre_r, pre_nxt;
  wdtw_post_t    post_r, post_nxt;
  logic          swen_r, swen_nxt;
  logic          to_r, to_nxt;
  logic          wrst_r, wrst_nxt;
  logic          wake_r, wake_nxt;
  logic          oscen_r, oscen_nxt;
  logic          lp_r, lp_nxt;

  logic [3:0]    post_sel;
  logic          pre_long;
  logic          win_dis;
  logic          fuse_en;
  logic          enabled;
  logic [6:0]    pre_last;
  wdtw_post_t    post_last;
  wdtw_post_t    win_open;
  logic          pre_wrap;
  logic          timeout;
  logic          clear_all;
  logic          early_clear;

  assign post_sel = watchdog_config_word[`WDTW_CFG_POST_MSB:`WDTW_CFG_POST_LSB];
  assign pre_long = watchdog_config_word[`WDTW_CFG_PRE_BIT];
  assign win_dis  = watchdog_config_word[`WDTW_CFG_WINDOW_DISABLE_BIT_BIT];
  assign fuse_en  = watchdog_config_word[`WDTW_CFG_FUSE_EN_BIT];

  // --------------------------------------------------------
  // Enable and oscillator
  // --------------------------------------------------------
  // Fuse wins over software; the soft bit only matters when fuse is 0
  assign enabled = fuse_en | swen_r;

  wdtw_rc_osc u_osc (
    .sys_clk (sys_clk),
    .rst     (rst),
    .osc     (osc_if.src)
  );
  assign osc_if.run = oscen_r;

  // --------------------------------------------------------
  // Prescaler and postscaler terminal counts
  // --------------------------------------------------------
  assign pre_last  = pre_long ? 7'(`WDTW_PRE_DIV_LONG - 1) : 7'(`WDTW_PRE_DIV_SHORT - 1);
  assign post_last = wdtw_post_t'((17'h00001 << post_sel) - 17'h00001);
  // Window opens at three quarters of the postscaled period
  assign win_open  = wdtw_post_t'((17'(post_last) + 17'h00001) - ((17'(post_last) + 17'h00001) >> 2));
  assign pre_wrap  = osc_if.tick && (pre_r == pre_last);
  assign timeout   = enabled && pre_wrap && (post_r == post_last);

  // Clears from the instruction stream and clock system
  // Only a clear in normal run counts, per the instruction semantics
  assign clear_all   = osc_switch_done || power_save_instr || low_power_exit ||
                       (watchdog_clear_instr && (st_r == WDTW_RUN));
  // Early clear: postscaler below the window in a ratio of at least 1:4
  assign early_clear = enabled && !win_dis && watchdog_clear_instr && (st_r == WDTW_RUN) &&
                       (post_r < win_open) && (post_sel >= 4'h2);

  // --------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------
  // Counters also run in low power; only the state changes there
  always_comb begin
    st_nxt    = st_r;
    pre_nxt   = pre_r;
    post_nxt  = post_r;
    swen_nxt  = swen_r;
    to_nxt    = to_r;
    wrst_nxt  = 1'b0;
    wake_nxt  = 1'b0;
    oscen_nxt = enabled;
    if (soft_enable_set) swen_nxt = 1'b1;
    else if (soft_enable_clr) swen_nxt = 1'b0;
    if (timeout_flag_clr) to_nxt = 1'b0;
    if (!enabled || clear_all) begin
      pre_nxt  = '0;
      post_nxt = '0;
    end else if (osc_if.tick) begin
      if (pre_wrap) begin
        pre_nxt  = '0;
        post_nxt = (post_r == post_last) ? '0 : post_r + 1'b1;
      end else begin
        pre_nxt = pre_r + 1'b1;
      end
    end
    case (st_r)
      WDTW_RUN: begin
        if (power_save_instr) begin
          st_nxt = WDTW_LOWPWR;
        end else if (timeout || early_clear) begin
          wrst_nxt = 1'b1;
          to_nxt   = timeout ? 1'b1 : to_nxt; // Set wins over clear
        end
      end
      WDTW_LOWPWR: begin
        if (low_power_exit) begin
          st_nxt = WDTW_RUN;
        end else if (timeout) begin
          st_nxt   = WDTW_WAKE;
          wake_nxt = 1'b1;
          to_nxt   = 1'b1;
        end
      end
      WDTW_WAKE: begin
        // Resume after the power-save point; counters start afresh
        st_nxt   = WDTW_RUN;
        pre_nxt  = '0;
        post_nxt = '0;
      end
      default: st_nxt = WDTW_RUN;
    endcase
    // Low-power status follows the state being entered
    lp_nxt = (st_nxt == WDTW_LOWPWR);
  end

  // --------------------------------------------------------
  // Registers; reset clears everything incl. soft enable
  // --------------------------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_r    <= WDTW_RUN;
      pre_r   <= '0;
      post_r  <= '0;
      swen_r  <= 1'b0;
      to_r    <= 1'b0;
      wrst_r  <= 1'b0;
      wake_r  <= 1'b0;
      oscen_r <= 1'b0;
      lp_r    <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      pre_r   <= pre_nxt;
      post_r  <= post_nxt;
      swen_r  <= swen_nxt;
      to_r    <= to_nxt;
      wrst_r  <= wrst_nxt;
      wake_r  <= wake_nxt;
      oscen_r <= oscen_nxt;
      lp_r    <= lp_nxt;
    end
  end

  assign low_power_rc_osc_en = oscen_r;
  assign soft_enable_bit     = swen_r;
  assign timeout_flag        = to_r;
  assign watchdog_reset      = wrst_r;
  assign wake_request        = wake_r;
  assign in_low_power        = lp_r;

  // --------------------------------------------------------
  // Assertions
  // --------------------------------------------------------
  a_fuse_keeps_on: assert property (@(posedge sys_clk) disable iff (rst)
    fuse_en |=> low_power_rc_osc_en)
    else $error("oscillator off while fuse enable set");
  a_osc_follows_en: assert property (@(posedge sys_clk) disable iff (rst)
    !enabled ##1 !enabled |-> !low_power_rc_osc_en)
    else $error("oscillator on while watchdog disabled");
  a_flag_sticky: assert property (@(posedge sys_clk) disable iff (rst)
    timeout_flag && !timeout_flag_clr |=> timeout_flag)
    else $error("timeout flag dropped without software clear");
  a_run_timeout_rst: assert property (@(posedge sys_clk) disable iff (rst)
    (st_r == WDTW_RUN) && timeout && !power_save_instr |=> watchdog_reset && timeout_flag)
    else $error("run-mode timeout missed reset or flag");
  a_sleep_wake: assert property (@(posedge sys_clk) disable iff (rst)
    (st_r == WDTW_LOWPWR) && timeout && !low_power_exit |=>
    (wake_request && !watchdog_reset) ##1 (st_r == WDTW_RUN))
    else $error("low-power timeout did not wake cleanly");
  a_clear_zeroes: assert property (@(posedge sys_clk) disable iff (rst)
    clear_all |=> (pre_r == '0) && (post_r == '0))
    else $error("counters not cleared");
  a_early_clear: assert property (@(posedge sys_clk) disable iff (rst)
    early_clear && !power_save_instr |=> watchdog_reset)
    else $error("early clear did not reset");
  a_pre_bound: assert property (@(posedge sys_clk) disable iff (rst)
    pre_r <= pre_last || $changed(pre_long))
    else $error("prescaler past its terminal count");
  a_soft_off: assert property (@(posedge sys_clk) disable iff (rst)
    !fuse_en && !soft_enable_bit |-> (pre_r == '0) || $past(enabled))
    else $error("counting while disabled");
  c_run_timeout: cover property (@(posedge sys_clk) disable iff (rst) watchdog_reset && timeout_flag);
  c_wake: cover property (@(posedge sys_clk) disable iff (rst) wake_request);
  c_early: cover property (@(posedge sys_clk) disable iff (rst) early_clear);
  c_lp_exit: cover property (@(posedge sys_clk) disable iff (rst) (st_r == WDTW_LOWPWR) && low_power_exit);
endmodule

/* File: dv/wdtw_core_test.sv */
// Self-checking testbench for the windowed watchdog core
`timescale 1ns/100ps
module wdtw_core_test;
  // ----------------------------------------------------------------
  // Signals and bookkeeping
  // ----------------------------------------------------------------
  typedef struct {int kind; int lo; int hi; int t0;} wdtw_note_t;
  logic       sys_clk;
  logic       rst;
  logic [7:0] cfg;
  logic       se_set, se_clr, to_clr, clr_i, ps_i, sw_done, lp_exit;
  logic       osc_en, swen, to_flag, wd_rst, wake, in_lp;
  int         err_total;
  int         compares;
  int         cyc;
  wdtw_note_t exp_q[$];
  wdtw_note_t note;

  wdtw_core DUT (
    .sys_clk              (sys_clk),
    .rst                  (rst),
    .watchdog_config_word (cfg),
    .soft_enable_set      (se_set),
    .soft_enable_clr      (se_clr),
    .timeout_flag_clr     (to_clr),
    .watchdog_clear_instr (clr_i),
    .power_save_instr     (ps_i),
    .osc_switch_done      (sw_done),
    .low_power_exit       (lp_exit),
    .low_power_rc_osc_en  (osc_en),
    .soft_enable_bit      (swen),
    .timeout_flag         (to_flag),
    .watchdog_reset       (wd_rst),
    .wake_request         (wake),
    .in_low_power         (in_lp)
  );

  // ----------------------------------------------------------------
  // Clock, cycle count and hang guard
  // ----------------------------------------------------------------
  always #25 sys_clk = ~sys_clk;

  // Ceiling sits just above the four long time-outs of the run
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc >= 99000) begin
      err_total = err_total + 1;
      $display("Error at %0t: run did not finish in time", $time);
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares = compares + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Kind 0 is a reset request, kind 1 a wake; window in cycles from now
  task automatic push(input int kind, input int lo, input int hi);
    exp_q.push_back('{kind, lo, hi, cyc});
  endtask

  task automatic wait_empty(input int lim);
    int k;
    k = 0;
    while (exp_q.size() != 0 && k < lim) begin
      @(negedge sys_clk);
      k++;
    end
    if (exp_q.size() != 0) begin
      err_total = err_total + 1;
      $display("Error at %0t: expected event never came", $time);
      exp_q.delete();
    end
  endtask

  // One-cycle strobe; 0 clear, 1 save, 2 switch, 3 exit, 4 set, 5 unset, 6 flag clear
  task automatic pulse(input int sel);
    @(negedge sys_clk);
    case (sel)
      0: clr_i = 1'b1;
      1: ps_i = 1'b1;
      2: sw_done = 1'b1;
      3: lp_exit = 1'b1;
      4: se_set = 1'b1;
      5: se_clr = 1'b1;
      default: to_clr = 1'b1;
    endcase
    @(negedge sys_clk);
    {clr_i, ps_i, sw_done, lp_exit, se_set, se_clr, to_clr} = '0;
  endtask

  task automatic do_reset();
    @(negedge sys_clk);
    rst = 1'b1;
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Event monitor: each pulse consumes the oldest note
  // ----------------------------------------------------------------
  // Sampled at the falling edge, where the registered outputs have settled
  always @(negedge sys_clk) begin
    if (rst === 1'b0 && (wd_rst === 1'b1 || wake === 1'b1)) begin
      if (exp_q.size() == 0) begin
        err_total = err_total + 1;
        $display("Error at %0t: unexpected reset or wake", $time);
      end else begin
        note = exp_q.pop_front();
        check(wake, note.kind[0]);
        check((cyc - note.t0) >= note.lo && (cyc - note.t0) <= note.hi, 1'b1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    cfg = 8'h00;
    {clr_i, ps_i, sw_done, lp_exit, se_set, se_clr, to_clr} = '0;
    err_total = 0;
    compares = 0;
    cyc = 0;
    void'($urandom(10));
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    check(swen, 1'b0);
    check(to_flag, 1'b0);
    check(osc_en, 1'b0);
    $display("Test reset values done");
    // Soft enable with the fuse off
    pulse(4);
    @(negedge sys_clk);
    check(swen, 1'b1);
    check(osc_en, 1'b1);
    pulse(5);
    repeat (2) @(negedge sys_clk);
    check(osc_en, 1'b0);
    pulse(4);
    do_reset();
    check(swen, 1'b0);
    $display("Test soft enable done");
    // Window mode, div-by-128, random postscale of 1:4 or above: a clear at count zero is early
    cfg = 8'h90 | 8'(2 + $urandom % 14);
    do_reset();
    repeat (3) @(negedge sys_clk);
    push(0, 0, 5);
    // Software owes a clear in the last quarter only; this one breaks that on purpose
    pulse(0);
    wait_empty(20);
    $display("Test early clear done");
    // Fuse on, div-by-32, 1:1: switch clears, then run-mode time-out
    cfg = 8'hc0;
    do_reset();
    repeat (3000 + $urandom % 1000) @(negedge sys_clk);
    pulse(2);
    push(0, 19000, 21000);
    pulse(5);
    check(osc_en, 1'b1);
    wait_empty(25000);
    repeat (50) @(negedge sys_clk);
    check(to_flag, 1'b1);
    pulse(6);
    @(negedge sys_clk);
    check(to_flag, 1'b0);
    $display("Test run time-out done");
    // Sleep: counter keeps running and wakes the device
    repeat ($urandom % 200) @(negedge sys_clk);
    pulse(1);
    push(1, 19000, 21000);
    repeat (3) @(negedge sys_clk);
    check(in_lp, 1'b1);
    wait_empty(25000);
    repeat (2) @(negedge sys_clk);
    // Sleep and idle status bits are software's to clear; the block only leaves its state
    check(in_lp, 1'b0);
    check(to_flag, 1'b1);
    // Clear instruction in run restarts the full period
    repeat (3000) @(negedge sys_clk);
    pulse(0);
    push(0, 19000, 21000);
    wait_empty(25000);
    $display("Test sleep wake done");
    // Exit by other cause restarts the count
    pulse(1);
    repeat (3000) @(negedge sys_clk);
    pulse(3);
    push(0, 19000, 21000);
    @(negedge sys_clk);
    check(in_lp, 1'b0);
    wait_empty(25000);
    $display("Test low power exit done");
    tally_and_finish();
  end
endmodule
